/* File: include/let_consts.vh */
// Constants for the link enhancement control register block.
// Assumes inclusion by bare name from the design files under src/.
`ifndef LET_CONSTS_VH
`define LET_CONSTS_VH

// Register map
`define LET_OFFSET        8'hf4
`define LET_RESET_VALUE   32'h00001000
`define LET_WRITE_MASK    32'h00003086

// Field positions
`define LET_THRESH_HI     13
`define LET_THRESH_LO     12
`define LET_PRIO_BIT      7
`define LET_GAP_BIT       2
`define LET_ACCEL_BIT     1
`define LET_GATE_BIT      22

// Read-only positions
`define LET_RSV_TOP_HI    31
`define LET_RSV_TOP_LO    14
`define LET_RSV_MID_HI    11
`define LET_RSV_MID_LO    8
`define LET_SPARE_BIT     6
`define LET_RSV_LOW_HI    5
`define LET_RSV_LOW_LO    3
`define LET_RSV_BIT       0

// Threshold field codes
`define LET_THR_2K        2'h0
`define LET_THR_1K7       2'h1
`define LET_THR_1K        2'h2
`define LET_THR_512       2'h3

// Threshold levels in bytes
`define LET_LVL_2K        12'h800
`define LET_LVL_1K7       12'h6cc
`define LET_LVL_1K        12'h400
`define LET_LVL_512       12'h200

`endif

/* File: src/let_start_gate.v */
// Transmit start decision for the asynchronous outbound FIFO.
// Assumes FIFO fill level and end-of-packet flag come from the datapath.
`include "let_consts.vh"

module let_start_gate (
  // Selected start level
  input  wire [1:0]  thresh_code,
  input  wire        force_saf,
  // FIFO state
  input  wire [11:0] fifo_level,
  input  wire        pkt_complete,
  // Decision
  output reg         start_ok,
  output reg  [11:0] start_level
);

  // Map field code to byte level
  function [11:0] level_of;
    input [1:0] code;
    begin
      case (code)
        `LET_THR_1K7: level_of = `LET_LVL_1K7;
        `LET_THR_1K:  level_of = `LET_LVL_1K;
        `LET_THR_512: level_of = `LET_LVL_512;
        default:      level_of = `LET_LVL_2K;
      endcase
    end
  endfunction

  // Start once whole packet held, or once level reached for levels below 2K without store-and-forward
  always @* begin
    if (force_saf || thresh_code == `LET_THR_2K) begin
      start_level = `LET_LVL_2K;
      start_ok    = pkt_complete; // RULE_06
    end else begin
      start_level = level_of(thresh_code);
      start_ok    = pkt_complete || (fifo_level >= start_level); // RULE_05
    end
  end

endmodule // let_start_gate

/* File: src/let_link_enh.v */
// Link enhancement control register and the options it steers.
// Assumes a simple synchronous register port and loader port on ref_clk.
`include "let_consts.vh"

// Summary of operation
// (RULE_01) Enhancements act only while control register bit 22 is set.
// (RULE_02) Bits 31 to 14 read as zero and cannot be written.
// (RULE_03) Bits 13:12 choose 2K, 1.7K, 1K or 512 byte start, reset 01.
// (RULE_04) After an underrun the retransmission waits for the whole packet.
// (RULE_05) Lower levels start at the level or at a complete packet.
// (RULE_06) The 2K level sends only after end of packet is in the FIFO.
// (RULE_07) A cleared retries register forces store-and-forward.
// (RULE_08) Bit 7 lets the link answer priority arbitration requests.
// (RULE_09) Bits 11 to 8 read as zero and cannot be written.
// (RULE_10) Bit 6 is unassigned and read-only; loader data there is ignored.
// (RULE_11) Bits 5 to 3 read as zero and cannot be written.
// (RULE_12) Writable bits load from software writes or from the EEPROM.
// (RULE_13) Bit 2 adds one idle cycle before the link drives PHY lines.
// (RULE_14) Bit 1 tells the PHY the link supports acceleration.
// (RULE_15) Bit 0 reads as zero and cannot be written.
// (RULE_16) Writes to read-only bits are ignored.
module let_link_enh (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Software register port
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  // Serial EEPROM loader
  input  wire        eeprom_load,
  input  wire [31:0] eeprom_data,
  // Host controller state
  input  wire [31:0] hc_control,
  input  wire        retries_zero,
  // Asynchronous outbound FIFO
  input  wire [11:0] fifo_level,
  input  wire        pkt_complete,
  input  wire        fifo_underrun,
  input  wire        pkt_done,
  output wire        tx_start,
  output wire [11:0] tx_level,
  // PHY link options
  input  wire        phy_ctl_request,
  output reg         phy_drive,
  output wire        prio_enable,
  output wire        accel_notify
);

  // Reset image of the register, split per field below
  localparam [31:0] reset_word = `LET_RESET_VALUE;

  // Stored writable fields; read-only positions have no storage
  reg  [1:0]  thresh_code;
  reg         prio_bit;
  reg         gap_bit;
  reg         accel_bit;
  // Next field values
  reg  [1:0]  next_thresh_code;
  reg         next_prio_bit;
  reg         next_gap_bit;
  reg         next_accel_bit;
  // Read image and retry state
  reg  [31:0] field_word;
  reg         retry_saf;
  reg         next_retry_saf;
  // PHY line turnaround
  reg         req_d;
  reg         next_phy_drive;
  // Decode and steering
  wire        sw_hit;
  wire        load_any;
  wire [31:0] load_word;
  wire        gate;
  wire        gap_on;
  wire        saf;
  wire        start_ok;

  // Address match, shared by the write and read paths
  function hits_reg;
    input [7:0] addr;
    begin
      hits_reg = (addr == `LET_OFFSET);
    end
  endfunction

  // Gate bit of the host controller control register
  assign gate = hc_control[`LET_GATE_BIT]; // RULE_01

  // Source select; a software write wins over a same-cycle loader word
  assign sw_hit    = reg_wr && hits_reg(reg_addr);
  assign load_any  = sw_hit || eeprom_load; // RULE_12
  assign load_word = sw_hit ? reg_wdata : eeprom_data;

  // Next field values; only writable positions are taken from a load
  always @* begin
    next_thresh_code = thresh_code;
    next_prio_bit    = prio_bit;
    next_gap_bit     = gap_bit;
    next_accel_bit   = accel_bit;
    if (load_any) begin // RULE_16
      next_thresh_code = load_word[`LET_THRESH_HI:`LET_THRESH_LO];
      next_prio_bit    = load_word[`LET_PRIO_BIT];
      next_gap_bit     = load_word[`LET_GAP_BIT];
      next_accel_bit   = load_word[`LET_ACCEL_BIT];
    end
  end

  // Start level field, reset to the 1.7K code
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      thresh_code <= reset_word[`LET_THRESH_HI:`LET_THRESH_LO]; // RULE_03
    end else begin
      thresh_code <= next_thresh_code;
    end
  end

  // Priority arbitration enable
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prio_bit <= reset_word[`LET_PRIO_BIT];
    end else begin
      prio_bit <= next_prio_bit;
    end
  end

  // Turnaround gap enable
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_bit <= reset_word[`LET_GAP_BIT];
    end else begin
      gap_bit <= next_gap_bit;
    end
  end

  // Acceleration notify enable
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      accel_bit <= reset_word[`LET_ACCEL_BIT];
    end else begin
      accel_bit <= next_accel_bit;
    end
  end

  // Read image: writable fields in place, every other position zero
  always @* begin
    field_word = 32'h00000000;
    field_word[`LET_RSV_TOP_HI:`LET_RSV_TOP_LO] = 18'h00000; // RULE_02
    field_word[`LET_THRESH_HI:`LET_THRESH_LO]   = thresh_code;
    field_word[`LET_RSV_MID_HI:`LET_RSV_MID_LO] = 4'h0; // RULE_09
    field_word[`LET_PRIO_BIT]                   = prio_bit;
    field_word[`LET_SPARE_BIT]                  = 1'b0; // RULE_10
    field_word[`LET_RSV_LOW_HI:`LET_RSV_LOW_LO] = 3'h0; // RULE_11
    field_word[`LET_GAP_BIT]                    = gap_bit;
    field_word[`LET_ACCEL_BIT]                  = accel_bit;
    field_word[`LET_RSV_BIT]                    = 1'b0; // RULE_15
  end

  // Register read; other offsets read zero
  always @* begin
    if (hits_reg(reg_addr)) begin
      reg_rdata = field_word;
    end else begin
      reg_rdata = 32'h00000000;
    end
  end

  // Underrun arms store-and-forward for the retry; the set wins a tie
  always @* begin
    next_retry_saf = retry_saf;
    if (fifo_underrun) begin
      next_retry_saf = 1'b1; // RULE_04
    end else if (pkt_done) begin
      next_retry_saf = 1'b0;
    end
  end

  // Retry state flop
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      retry_saf <= 1'b0;
    end else begin
      retry_saf <= next_retry_saf;
    end
  end

  // Store-and-forward when retrying, retries cleared or gate off
  assign saf = retry_saf || retries_zero || !gate; // RULE_07

  // Start decision for the asynchronous outbound FIFO
  let_start_gate u_gate (
    .thresh_code (thresh_code),
    .force_saf   (saf),
    .fifo_level  (fifo_level),
    .pkt_complete(pkt_complete),
    .start_ok    (start_ok),
    .start_level (tx_level)
  );
  assign tx_start = start_ok;

  // Link options reach the link only through the gate
  assign prio_enable  = gate && prio_bit; // RULE_08
  assign accel_notify = gate && accel_bit; // RULE_14
  assign gap_on       = gate && gap_bit;

  // Drive follows the request; the gap holds it back one more cycle
  always @* begin
    if (gap_on) begin
      next_phy_drive = phy_ctl_request && req_d; // RULE_13
    end else begin
      next_phy_drive = phy_ctl_request;
    end
  end

  // Request delay and drive flops
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_d     <= 1'b0;
      phy_drive <= 1'b0;
    end else begin
      req_d     <= phy_ctl_request;
      phy_drive <= next_phy_drive;
    end
  end

endmodule // let_link_enh

/* File: testbench/let_monitor.sv */
// Port checks of the link enhancement block.
// Assumes one ref_clk domain; bound to let_link_enh.
module let_monitor (
  // Clock and reset
  input logic        ref_clk,
  input logic        rst,
  // Register port
  input logic        reg_wr,
  input logic [7:0]  reg_addr,
  input logic [31:0] reg_wdata,
  input logic [31:0] reg_rdata,
  // Host controller state and FIFO causes
  input logic [31:0] hc_control,
  input logic        retries_zero,
  input logic        pkt_complete,
  input logic [11:0] fifo_level,
  // Watched outputs and request
  input logic        tx_start,
  input logic [11:0] tx_level,
  input logic        phy_ctl_request,
  input logic        phy_drive,
  input logic        prio_enable,
  input logic        accel_notify
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire at = reg_addr == 8'hf4;
  wire en = hc_control[22];
  rsv_zero_a:
  assert property (at |-> !(reg_rdata & 32'hffffcf79)) else $error("rsv");
  wr_back_a:
  assert property (reg_wr && at ##1 at |->
    reg_rdata == ($past(reg_wdata) & 32'h3086)) else $error("wr");
  gate_off_a:
  assert property (!en |-> tx_level == 12'h800 && !prio_enable)
    else $error("gate");
  saf_retry_a:
  assert property (retries_zero |-> tx_level == 12'h800) else $error("rz");
  prio_accel_a:
  assert property (en && at |-> prio_enable == reg_rdata[7] &&
    accel_notify == reg_rdata[1]) else $error("opt");
  lvl_start_a:
  assert property (tx_level != 12'h800 && fifo_level >= tx_level |->
    tx_start) else $error("lvl");
  saf_hold_a:
  assert property (tx_level == 12'h800 |-> tx_start == pkt_complete)
    else $error("saf");
  turn_gap_a:
  assert property (en && at && reg_rdata[2] && $rose(phy_ctl_request)
    ##1 phy_ctl_request |-> !phy_drive ##1 phy_drive) else $error("gap");
endmodule // let_monitor
bind let_link_enh let_monitor mon_u (.*);

/* File: testbench/let_ee_model.sv */
// Serial EEPROM loader model.
// Assumes a one-cycle load pulse per word.
module let_ee_model (
  input  logic        ref_clk, go,
  output logic        eeprom_load = 0,
  output logic [31:0] eeprom_data = 0
);
  // One word per request, idle data toggles
  always @(posedge ref_clk) begin
    eeprom_load <= go;
    eeprom_data <= go ? 32'hffffffff : ~eeprom_data;
  end
endmodule // let_ee_model

/* File: testbench/tb_top.sv */
// Self-checking bench of the link enhancement block.
// Assumes design, checker and loader model compiled first.
`include "let_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 0, rst = 1, reg_wr = 0, go = 0, retries_zero = 0;
  logic        pkt_complete = 0, fifo_underrun = 0, pkt_done = 0;
  logic        phy_ctl_request = 0, eeprom_load, tx_start, phy_drive;
  logic        prio_enable, accel_notify;
  logic [7:0]  reg_addr = 8'hf4;
  logic [11:0] fifo_level = 0, tx_level;
  logic [11:0] lv [4] = '{12'h800, 12'h6cc, 12'h400, 12'h200};
  logic [31:0] reg_wdata = 0, hc_control = 0, reg_rdata, eeprom_data;
  int          failures = 0, compares = 0;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("mismatch %0t got %0h want %0h", $time, (a), (b)); end end
  let_link_enh dut_u (.*);
  let_ee_model ee_u (.ref_clk, .go, .eeprom_load, .eeprom_data);
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic wr(input logic [31:0] d);
    @(posedge ref_clk) {reg_wr, reg_wdata} <= {1'b1, d};
    @(posedge ref_clk) reg_wr <= 0;
    @(negedge ref_clk);
  endtask
  task automatic t_regs;
    `CHK(reg_rdata, `LET_RESET_VALUE)
    wr('1);
    `CHK(reg_rdata[31:14], 0)
    `CHK(reg_rdata[11:8], 0)
    `CHK(reg_rdata[6], 0)
    `CHK(reg_rdata[5:3], 0)
    `CHK(reg_rdata[0], 0)
    `CHK(reg_rdata, `LET_WRITE_MASK)
    @(posedge ref_clk) reg_addr <= 8'hf0;
    @(negedge ref_clk) `CHK(reg_rdata, 0)
    wr(0);
    @(posedge ref_clk) reg_addr <= 8'hf4;
    @(negedge ref_clk) `CHK(reg_rdata, `LET_WRITE_MASK)
  endtask
  task automatic t_lvl;
    @(posedge ref_clk) hc_control <= 32'h00400000;
    for (int i = 0; i < 4; i++) begin
      wr(i << 12);
      `CHK(tx_level, lv[i])
    end
    @(posedge ref_clk) fifo_level <= 12'h1ff;
    @(negedge ref_clk) `CHK(tx_start, 1'b0)
    @(posedge ref_clk) pkt_complete <= 1;
    @(negedge ref_clk) `CHK(tx_start, 1'b1)
    @(posedge ref_clk) {pkt_complete, fifo_level} <= {1'b0, 12'h200};
    @(negedge ref_clk) `CHK(tx_start, 1'b1)
    @(posedge ref_clk) fifo_underrun <= 1;
    @(posedge ref_clk) fifo_underrun <= 0;
    @(negedge ref_clk) `CHK({tx_start, tx_level}, {1'b0, 12'h800})
    @(posedge ref_clk) pkt_complete <= 1;
    @(negedge ref_clk) `CHK(tx_start, 1'b1)
    @(posedge ref_clk) {pkt_complete, pkt_done} <= 2'b01;
    @(posedge ref_clk) pkt_done <= 0;
    @(negedge ref_clk) `CHK(tx_level, 12'h200)
    @(posedge ref_clk) retries_zero <= 1;
    @(negedge ref_clk) `CHK({tx_start, tx_level}, {1'b0, 12'h800})
    @(posedge ref_clk) {retries_zero, hc_control} <= 0;
    @(negedge ref_clk) `CHK(tx_level, 12'h800)
  endtask
  task automatic t_ee;
    @(posedge ref_clk) go <= 1;
    @(posedge ref_clk) go <= 0;
    @(posedge ref_clk);
    @(negedge ref_clk) `CHK(reg_rdata, `LET_WRITE_MASK)
  endtask
  task automatic t_phy;
    `CHK({prio_enable, accel_notify}, 2'b00)
    @(posedge ref_clk) {hc_control, phy_ctl_request} <= {32'h400000, 1'b1};
    @(negedge ref_clk) `CHK({prio_enable, accel_notify}, 2'b11)
    @(negedge ref_clk) `CHK(phy_drive, 1'b0)
    @(negedge ref_clk) `CHK(phy_drive, 1'b1)
    @(posedge ref_clk) phy_ctl_request <= 0;
    wr(32'h00001082);
    @(posedge ref_clk) phy_ctl_request <= 1;
    @(negedge ref_clk) `CHK(phy_drive, 1'b0)
    @(negedge ref_clk) `CHK(phy_drive, 1'b1)
  endtask
  task automatic t_rst;
    @(posedge ref_clk) rst <= 1;
    @(posedge ref_clk) rst <= 0;
    @(negedge ref_clk) `CHK({reg_rdata, phy_drive}, {32'h1000, 1'b0})
    @(posedge ref_clk) phy_ctl_request <= 0;
  endtask
  task report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    @(negedge ref_clk);
    t_regs;
    t_lvl;
    t_ee;
    t_phy;
    t_rst;
    report_and_stop;
  end
  // Watchdog against a hang
  initial begin
    repeat (500) @(posedge ref_clk);
    failures++;
    report_and_stop;
  end
endmodule // tb_top
